// >>> rtl/nvsram_host_pkg.sv
// Purpose: Shared constants and types for the nonvolatile SRAM host controller.
// Assumes: Host clock of 250 MHz, one address pin per device address line.
// Notes: Access and store-request pull times are conservative host-side figures.
package nvsram_host_pkg;

    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int SEQ_LEN = 6;
    localparam int MATCH_W = 14;
    localparam int CNT_W = 24;

    localparam int CLK_PERIOD_NS = 4;
    localparam int ACCESS_TIME_NS = 45;
    localparam int ACCESS_CYC = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_CYC = 2;
    localparam int READ_CYC = ACCESS_CYC + SYNC_CYC;
    localparam int HSB_PULSE_NS = 40;
    localparam int HSB_PULSE_CYC = (HSB_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [MATCH_W-1:0] SEQ_ADDR0 = 14'h0e38;
    localparam logic [MATCH_W-1:0] SEQ_ADDR1 = 14'h31c7;
    localparam logic [MATCH_W-1:0] SEQ_ADDR2 = 14'h03e0;
    localparam logic [MATCH_W-1:0] SEQ_ADDR3 = 14'h3c1f;
    localparam logic [MATCH_W-1:0] SEQ_ADDR4 = 14'h303f;
    localparam logic [MATCH_W-1:0] SEQ_STORE = 14'h0fc0;
    localparam logic [MATCH_W-1:0] SEQ_RECALL = 14'h0c63;

    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_WRITE = 3'h1,
        OP_SW_STORE = 3'h2,
        OP_SW_RECALL = 3'h3,
        OP_HW_STORE = 3'h4
    } op_e;

    typedef struct packed {
        op_e op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } cmd_s;

endpackage

// >>> rtl/nvsram_host.sv
// Purpose: Host controller that drives a byte-wide nonvolatile SRAM through its pins.
// Assumes: Device pins are asynchronous; inputs pass two flip-flops before use.
// Notes: One command at a time; store_busy_n is driven open-drain (low only).
//
// Contract
// - Host holds address stable across the whole write.
// - Host drives valid data before the terminating write enable rise.
// - Host keeps output enable high throughout a write.
// - Software sequence: six chip-enable reads starting 0x0E38, 0x31C7, 0x03E0.
// - Fourth and fifth reads are 0x3C1F and 0x303F.
module nvsram_host
    import nvsram_host_pkg::*;
#(
    parameter int POWERUP_RECALL_CYC = 5000,
    parameter int NV_OP_CYC = 5000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire nvsram_host_pkg::cmd_s cmd,
    input wire logic cmd_valid,
    output logic cmd_ready,
    output logic [nvsram_host_pkg::DATA_W-1:0] rdata,
    output logic done,
    output logic ce_n,
    output logic we_n,
    output logic oe_n,
    output logic [nvsram_host_pkg::ADDR_W-1:0] address_lines,
    output logic [nvsram_host_pkg::DATA_W-1:0] data_lines_out,
    output logic data_lines_oe,
    input wire logic [nvsram_host_pkg::DATA_W-1:0] data_lines_in,
    output logic store_busy_n_out,
    output logic store_busy_n_oe,
    input wire logic store_busy_n_in
);
    import nvsram_host_pkg::*;

    typedef enum logic [7:0] {
        ST_INIT = 8'h01,
        ST_IDLE = 8'h02,
        ST_SETUP = 8'h04,
        ST_PULSE = 8'h08,
        ST_HOLD = 8'h10,
        ST_PULL = 8'h20,
        ST_RELEASE = 8'h40,
        ST_NVWAIT = 8'h80
    } state_e;

    function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] step, input logic recall);
        logic [MATCH_W-1:0] a;
        a = SEQ_ADDR0;
        case (step)
            3'h0: a = SEQ_ADDR0;
            3'h1: a = SEQ_ADDR1;
            3'h2: a = SEQ_ADDR2;
            3'h3: a = SEQ_ADDR3;
            3'h4: a = SEQ_ADDR4;
            default: a = recall ? SEQ_RECALL : SEQ_STORE;
        endcase
        return {1'b0, a};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin input synchronisers.
    logic [DATA_W-1:0] data_meta_r, data_sync_r;
    logic busy_meta_r, busy_sync_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_meta_r <= '0;
            data_sync_r <= '0;
            busy_meta_r <= 1'b1;
            busy_sync_r <= 1'b1;
        end else begin
            data_meta_r <= data_lines_in;
            data_sync_r <= data_meta_r;
            busy_meta_r <= store_busy_n_in;
            busy_sync_r <= busy_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer.
    state_e state_r;
    logic [CNT_W-1:0] cnt_r;
    cmd_s cur_r;
    logic [2:0] step_r;
    logic is_seq;
    logic is_write;
    logic last_step;

    assign is_seq = (cur_r.op == OP_SW_STORE) || (cur_r.op == OP_SW_RECALL);
    assign is_write = (cur_r.op == OP_WRITE);
    assign last_step = (step_r == 3'(SEQ_LEN - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_INIT;
            cnt_r <= '0;
            cur_r <= '0;
            step_r <= '0;
            cmd_ready <= 1'b0;
            done <= 1'b0;
            rdata <= '0;
            ce_n <= 1'b1;
            we_n <= 1'b1;
            oe_n <= 1'b1;
            address_lines <= '0;
            data_lines_out <= '0;
            data_lines_oe <= 1'b0;
            store_busy_n_out <= 1'b0;
            store_busy_n_oe <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state_r)
                ST_INIT: begin
                    // Controls stay high through the automatic recall.
                    if (cnt_r == CNT_W'(POWERUP_RECALL_CYC - 1)) begin
                        cnt_r <= '0;
                        state_r <= ST_IDLE;
                        cmd_ready <= busy_sync_r;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                ST_IDLE: begin
                    // Accept only while no store runs.
                    cmd_ready <= busy_sync_r;
                    if (cmd_valid && cmd_ready && busy_sync_r) begin
                        cur_r <= cmd;
                        cmd_ready <= 1'b0;
                        step_r <= '0;
                        cnt_r <= '0;
                        if (cmd.op == OP_HW_STORE) begin
                            // Open-drain pull starts the pin store.
                            store_busy_n_oe <= 1'b1;
                            state_r <= ST_PULL;
                        end else begin
                            // Address settles with every control high.
                            if (cmd.op == OP_SW_STORE || cmd.op == OP_SW_RECALL) begin
                                address_lines <= seq_addr(3'h0, cmd.op == OP_SW_RECALL);
                            end else begin
                                address_lines <= cmd.addr;
                            end
                            data_lines_out <= cmd.wdata;
                            data_lines_oe <= (cmd.op == OP_WRITE);
                            state_r <= ST_SETUP;
                        end
                    end
                end
                ST_SETUP: begin
                    // Sequence steps wait out a store, never interleaving accesses.
                    if (busy_sync_r) begin
                        ce_n <= 1'b0;
                        we_n <= !is_write;
                        oe_n <= is_write || is_seq;
                        cnt_r <= '0;
                        state_r <= ST_PULSE;
                    end
                end
                ST_PULSE: begin
                    if (cnt_r == CNT_W'(READ_CYC - 1)) begin
                        // Chip enable ends the access; write data latches here.
                        ce_n <= 1'b1;
                        we_n <= 1'b1;
                        oe_n <= 1'b1;
                        if (cur_r.op == OP_READ) begin
                            rdata <= data_sync_r;
                        end
                        cnt_r <= '0;
                        state_r <= ST_HOLD;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                ST_HOLD: begin
                    data_lines_oe <= 1'b0;
                    if (is_seq && !last_step) begin
                        // Six chip-enable reads, low 14 bits only.
                        step_r <= step_r + 1'b1;
                        address_lines <= seq_addr(step_r + 3'h1, cur_r.op == OP_SW_RECALL);
                        state_r <= ST_SETUP;
                    end else if (is_seq) begin
                        // Device stores or recalls now; hold off.
                        cnt_r <= '0;
                        state_r <= ST_NVWAIT;
                    end else begin
                        done <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                ST_PULL: begin
                    if (cnt_r == CNT_W'(HSB_PULSE_CYC - 1)) begin
                        store_busy_n_oe <= 1'b0;
                        cnt_r <= '0;
                        state_r <= ST_RELEASE;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                ST_RELEASE: begin
                    // Let the released pin reach the synchroniser before trusting it.
                    if (cnt_r == CNT_W'(SYNC_CYC + 1)) begin
                        cnt_r <= '0;
                        state_r <= ST_NVWAIT;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                ST_NVWAIT: begin
                    // Device busy low covers the store; also wait the fixed time.
                    if (cnt_r >= CNT_W'(NV_OP_CYC - 1) && busy_sync_r) begin
                        done <= 1'b1;
                        cnt_r <= '0;
                        state_r <= ST_IDLE;
                    end else if (cnt_r < CNT_W'(NV_OP_CYC - 1)) begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                default: state_r <= ST_INIT;
            endcase
        end
    end

endmodule // nvsram_host

// >>> tb/nvsram_host_props.sv
// Purpose: Port-level checks of the nonvolatile SRAM host controller.
// Assumes: Access and pull lengths follow the hand-over timing at 250 MHz.
// Notes: Bound to every controller instance.
module nvsram_host_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic done,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [14:0] address_lines,
    input wire logic [7:0] data_lines_out,
    input wire logic data_lines_oe,
    input wire logic store_busy_n_out,
    input wire logic store_busy_n_oe,
    input wire logic store_busy_n_in
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    a_access_len: assert property ($fell(ce_n) |-> ##14 $rose(ce_n))
        else $error("access pulse length wrong");
    a_write_in_ce: assert property (!we_n |-> !ce_n)
        else $error("write enable outside chip enable");
    a_addr_held: assert property (!ce_n && $past(!ce_n) |-> $stable(address_lines))
        else $error("address moved during access");
    a_wdata_held: assert property (!we_n && $past(!we_n) |-> $stable(data_lines_out))
        else $error("write data moved");
    a_write_oe_off: assert property (!we_n |-> oe_n && data_lines_oe)
        else $error("output enable low or data undriven in write");
    a_no_busy_start: assert property ((ce_n && !store_busy_n_in) [*4] |=> ce_n)
        else $error("access started while busy");
    a_pull_len: assert property ($rose(store_busy_n_oe) |->
        store_busy_n_oe [*8] ##1 store_busy_n_oe [*2] ##1 !store_busy_n_oe)
        else $error("store request pull length wrong");
    a_pull_od: assert property (store_busy_n_oe |-> !store_busy_n_out)
        else $error("busy line driven high");
    a_done_once: assert property (done |=> !done)
        else $error("done longer than one cycle");
    c_write: cover property ($fell(we_n));
    c_read: cover property ($fell(ce_n) && we_n);
    c_pull: cover property ($rose(store_busy_n_oe));
endmodule // nvsram_host_props
bind nvsram_host nvsram_host_props nvsram_host_props_i (.clk(clk), .rst_n(rst_n), .done(done),
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .address_lines(address_lines),
    .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
    .store_busy_n_out(store_busy_n_out), .store_busy_n_oe(store_busy_n_oe),
    .store_busy_n_in(store_busy_n_in));

// >>> tb/nvsram_dev_model.sv
// Purpose: Behavioural model of the nonvolatile SRAM device.
// Assumes: Pins sampled on the bench clock; operation times are shortened.
// Notes: Supply loss is a level input; the first clock edge runs the power-up recall.
module nvsram_dev_model #(
    parameter int NV_T = 12,
    parameter int GRACE = 4
) (
    input wire logic clk,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [14:0] addr,
    input wire logic [7:0] din,
    output logic [7:0] dout,
    input wire logic busy_n,
    input wire logic vcc_low,
    output logic pull,
    output logic [7:0] stores,
    output logic [7:0] recalls
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:32767];
    logic [7:0] nv [0:32767];
    logic [13:0] tbl [0:4] = '{14'h0e38, 14'h31c7, 14'h03e0, 14'h3c1f, 14'h303f};
    logic ce_q = 1'b1;
    logic we_q = 1'b1;
    logic lo_q = 1'b1;
    logic arm = 1'b0;
    logic [14:0] a_q = '0;
    logic [2:0] step = '0;
    logic wr = 1'b0;
    logic st = 1'b0;
    logic [7:0] last = '0;
    logic rd_on;
    int tmr = 0;
    int grace = 0;
    initial stores = '0;
    initial recalls = '0;
    assign rd_on = !ce_n && !oe_n && we_n && busy_n && tmr == 0;
    assign dout = rd_on ? mem[addr] : ~last;
    assign pull = tmr != 0 && st;
    ////////////////////////////////////////////////////////////////////////////
    task automatic nv_op(input logic s);
        st <= s;
        tmr <= NV_T;
        wr <= 1'b0;
        arm <= 1'b0;
        for (int i = 0; i < 32768; i++) begin
            if (s) nv[i] = mem[i];
            else mem[i] = nv[i];
        end
        if (s) stores <= stores + 8'h01;
        else recalls <= recalls + 8'h01;
    endtask
    always @(posedge clk) begin
        ce_q <= ce_n;
        we_q <= we_n;
        a_q <= addr;
        lo_q <= vcc_low;
        if ((ce_q && !ce_n) || (we_q && !we_n)) arm <= busy_n;
        if (rd_on) last <= mem[addr];
        if (tmr > 0) tmr <= tmr - 1;
        if (!ce_q && ce_n && tmr == 0) begin
            if (!we_q) begin
                if (arm) begin
                    mem[a_q] = din;
                    wr <= 1'b1;
                end
                step <= '0;
            end else if (step == 3'h5) begin
                if (a_q[13:0] == 14'h0fc0) nv_op(1'b1);
                else if (a_q[13:0] == 14'h0c63) nv_op(1'b0);
                step <= '0;
            end else if (a_q[13:0] == tbl[step]) step <= step + 3'h1;
            else step <= {2'b00, a_q[13:0] == tbl[0]};
        end
        grace <= (!busy_n && !pull && tmr == 0) ? grace + 1 : 0;
        if (grace == GRACE && wr) nv_op(1'b1);
        if (vcc_low && !lo_q && wr) nv_op(1'b1);
        if (!vcc_low && lo_q) nv_op(1'b0);
    end
endmodule // nvsram_dev_model

// >>> tb/tb_nvsram_host.sv
// Purpose: Self-checking bench of the nonvolatile SRAM host controller.
// Assumes: Short power-up and store counts keep the run brief.
// Notes: Expected bytes and operation counts come from the stimulus.
module tb_nvsram_host
    import nvsram_host_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    cmd_s cmd = '0;
    logic cmd_valid = 1'b0;
    logic vcc_low = 1'b0;
    logic cmd_ready, done, ce_n, we_n, oe_n, d_oe, h_out, h_oe, pull, busy_w;
    logic [7:0] rdata, d_out, d_in, stores, recalls;
    logic [14:0] addr;
    int bad_count = 0;
    int n_tests = 0;
    always #2 clk = ~clk;
    assign busy_w = !(h_oe && !h_out) && !pull;
    nvsram_host #(.POWERUP_RECALL_CYC(20), .NV_OP_CYC(20)) nvsram_host_i (.clk(clk),
        .rst_n(rst_n), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rdata(rdata),
        .done(done), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .address_lines(addr),
        .data_lines_out(d_out), .data_lines_oe(d_oe), .data_lines_in(d_in),
        .store_busy_n_out(h_out), .store_busy_n_oe(h_oe), .store_busy_n_in(busy_w));
    nvsram_dev_model nvsram_dev_model_i (.clk(clk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
        .addr(addr), .din(d_out), .dout(d_in), .busy_n(busy_w), .vcc_low(vcc_low), .pull(pull),
        .stores(stores), .recalls(recalls));
    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic run(input op_e op, input logic [14:0] a, input logic [7:0] d);
        int i;
        @(posedge clk);
        #1 cmd = '{op, a, d};
        cmd_valid = 1'b1;
        for (i = 0; i < 3000 && cmd_ready !== 1'b1; i++) @(posedge clk) #1;
        @(posedge clk);
        #1 cmd_valid = 1'b0;
        for (i = i; i < 3000 && done !== 1'b1; i++) @(posedge clk) #1;
        if (i >= 3000) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, done, 1'b1);
            summarize();
        end
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        run(OP_WRITE, 15'h0000, 8'h5a);
        run(OP_WRITE, 15'h7fff, 8'ha5);
        run(OP_READ, 15'h0000, 8'h00);
        check(rdata, 8'h5a);
        run(OP_READ, 15'h7fff, 8'h00);
        check(rdata, 8'ha5);
        run(OP_SW_STORE, 15'h0000, 8'h00);
        check(stores, 8'h01);
        run(OP_SW_STORE, 15'h0000, 8'h00);
        check(stores, 8'h02);
        run(OP_WRITE, 15'h0000, 8'h11);
        run(OP_SW_RECALL, 15'h0000, 8'h00);
        check(recalls, 8'h02);
        run(OP_READ, 15'h0000, 8'h00);
        check(rdata, 8'h5a);
        run(OP_HW_STORE, 15'h0000, 8'h00);
        check(stores, 8'h02);
        run(OP_WRITE, 15'h4e38, 8'h33);
        run(OP_HW_STORE, 15'h0000, 8'h00);
        check(stores, 8'h03);
        run(OP_READ, 15'h4e38, 8'h00);
        check(rdata, 8'h33);
        run(OP_READ, 15'h0e38, 8'h00);
        run(OP_READ, 15'h31c7, 8'h00);
        run(OP_WRITE, 15'h03e0, 8'h44);
        run(OP_READ, 15'h03e0, 8'h00);
        run(OP_READ, 15'h3c1f, 8'h00);
        run(OP_READ, 15'h303f, 8'h00);
        run(OP_READ, 15'h0fc0, 8'h00);
        check(stores, 8'h03);
        run(OP_WRITE, 15'h0001, 8'h77);
        vcc_low = 1'b1;
        repeat (30) @(posedge clk);
        #1 vcc_low = 1'b0;
        repeat (30) @(posedge clk);
        check(stores, 8'h04);
        check(recalls, 8'h03);
        run(OP_READ, 15'h0001, 8'h00);
        check(rdata, 8'h77);
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("[FAIL] %0t got %h exp %h", $time, 1'b0, 1'b1);
        summarize();
    end
endmodule // tb_nvsram_host
